// ---- inc/wiper_port_pkg.sv ----
// Shared constants for the dual wiper serial command port
package wiper_port_pkg;
    localparam int CODE_WIDTH = 8;
    localparam int FRAME_SHORT = 8;
    localparam int FRAME_LONG = 16;
    localparam logic [1:0] CMD_WRITE_WIPER = 2'h0;
    localparam logic [1:0] CMD_WRITE_STORED = 2'h1;
    localparam logic [1:0] CMD_SAVE = 2'h2;
    localparam logic [1:0] CMD_RESTORE = 2'h3;
    localparam logic [1:0] TARGET_NONE = 2'h0;
    localparam logic [1:0] TARGET_A = 2'h1;
    localparam logic [1:0] TARGET_B = 2'h2;
    localparam logic [1:0] TARGET_BOTH = 2'h3;
    localparam int CMD_POS = 12;
    localparam int TARGET_POS = 8;
    localparam logic [7:0] STORED_RESET = 8'h80;
    localparam int CLOCK_MHZ = 100;
    localparam int POWERUP_NS = 5000;
    localparam int POWERUP_CYCLES = POWERUP_NS * CLOCK_MHZ / 1000;
    localparam int STORE_BUSY_MS = 12;
    localparam int STORE_BUSY_CYCLES = STORE_BUSY_MS * CLOCK_MHZ * 1000;
    localparam int LINK_HALF_CYCLES = 10;
endpackage : wiper_port_pkg

// ---- inc/wiper_link_if.sv ----
// Three-wire write-only link between host and wiper device
`timescale 1ns/1ns
interface wiper_link_if;
    logic select_b;
    logic link_clock;
    logic serial_data;
    modport host (output select_b, output link_clock, output serial_data);
    modport device (input select_b, input link_clock, input serial_data);
endinterface : wiper_link_if

// ---- rtl/wiper_device.sv ----
// Device end: shifts frames in, executes wiper and store commands
`timescale 1ns/1ns
module wiper_device #(
    parameter int WIDTH = wiper_port_pkg::CODE_WIDTH
) (
    input wire logic i_clock,                 // System clock
    input wire logic i_rst_b,                 // Async reset, also power-up
    wiper_link_if.device link,                // Serial link from host, inputs only
    output logic [WIDTH-1:0] o_wiper_a,       // Wiper A tap code
    output logic [WIDTH-1:0] o_wiper_b,       // Wiper B tap code
    output logic [WIDTH-1:0] o_stored_a,      // Stored A code
    output logic [WIDTH-1:0] o_stored_b,      // Stored B code
    output logic o_ready,                     // Power-up load done
    output logic o_store_busy                 // Nonvolatile store in progress
);
    typedef enum logic [1:0] {POWER_UP = 2'b00, IDLE = 2'b01} state_t;

    state_t state;
    logic [2:0] sync_sel, sync_clk, sync_dat;
    logic sel_q, clk_q;
    logic [15:0] shift;
    logic [4:0] count;
    logic [$clog2(wiper_port_pkg::POWERUP_CYCLES+1)-1:0] boot_count;
    logic [31:0] busy_count;
    logic sel_now, clk_now, dat_now, clk_rise, sel_rise, sel_fall;
    logic [1:0] cmd, target;
    logic [WIDTH-1:0] code;
    logic valid, to_a, to_b;

    // Three-stage sampling; a select or clock level counts once stages two and three agree, data is taken from stage three
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_sel <= 3'h7;
            sync_clk <= 3'h0;
            sync_dat <= 3'h0;
        end else begin
            sync_sel <= {sync_sel[1:0], link.select_b};
            sync_clk <= {sync_clk[1:0], link.link_clock};
            sync_dat <= {sync_dat[1:0], link.serial_data};
        end
    end

    assign sel_now = (sync_sel[2] == sync_sel[1]) ? sync_sel[1] : sel_q;
    assign clk_now = (sync_clk[2] == sync_clk[1]) ? sync_clk[1] : clk_q;
    assign dat_now = sync_dat[2];

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_q <= 1'b1;
            clk_q <= 1'b0;
        end else begin
            sel_q <= sel_now;
            clk_q <= clk_now;
        end
    end

    assign clk_rise = clk_now && !clk_q;
    assign sel_rise = sel_now && !sel_q;
    assign sel_fall = !sel_now && sel_q;

    // Shifting; count saturates so overlong frames stay invalid
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift <= 16'h0000;
            count <= 5'h00;
        end else if (sel_fall) begin
            count <= 5'h00;
        end else if (!sel_now && clk_rise && state == IDLE) begin
            shift <= {shift[14:0], dat_now};
            if (count != 5'h1F) begin
                count <= count + 5'h01;
            end
        end
    end

    // Decode: an 8-clock frame has the header in the low byte
    always_comb begin
        if (count == 5'(wiper_port_pkg::FRAME_SHORT)) begin
            cmd = shift[5:4];
            target = shift[1:0];
        end else begin
            cmd = shift[wiper_port_pkg::CMD_POS+1:wiper_port_pkg::CMD_POS];
            target = shift[wiper_port_pkg::TARGET_POS+1:wiper_port_pkg::TARGET_POS];
        end
        code = shift[WIDTH-1:0];
        if (count == 5'(wiper_port_pkg::FRAME_LONG)) begin
            valid = 1'b1;
        end else if (count == 5'(wiper_port_pkg::FRAME_SHORT)) begin
            valid = cmd[1];
        end else begin
            valid = 1'b0;
        end
        if (target == wiper_port_pkg::TARGET_NONE) begin
            valid = 1'b0;
        end
        if (!cmd[1] && target == wiper_port_pkg::TARGET_BOTH) begin
            valid = 1'b0;
        end
        to_a = target[0];
        to_b = target[1];
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= POWER_UP;
            boot_count <= '0;
        end else if (state == POWER_UP) begin
            if (boot_count == ($bits(boot_count))'(wiper_port_pkg::POWERUP_CYCLES - 1)) begin
                state <= IDLE;
            end else begin
                boot_count <= boot_count + 1'b1;
            end
        end else begin
            state <= IDLE;
        end
    end

    // Stored values survive only in simulation; reset models factory midscale
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stored_a <= wiper_port_pkg::STORED_RESET;
            o_stored_b <= wiper_port_pkg::STORED_RESET;
        end else if (state == IDLE && sel_rise && valid) begin
            if (cmd == wiper_port_pkg::CMD_WRITE_STORED) begin
                if (to_a) o_stored_a <= code;
                if (to_b) o_stored_b <= code;
            end else if (cmd == wiper_port_pkg::CMD_SAVE) begin
                if (to_a) o_stored_a <= o_wiper_a;
                if (to_b) o_stored_b <= o_wiper_b;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wiper_a <= '0;
            o_wiper_b <= '0;
        end else if (state == POWER_UP) begin
            o_wiper_a <= o_stored_a;
            o_wiper_b <= o_stored_b;
        end else if (sel_rise && valid) begin
            if (cmd == wiper_port_pkg::CMD_WRITE_WIPER) begin
                if (to_a) o_wiper_a <= code;
                if (to_b) o_wiper_b <= code;
            end else if (cmd == wiper_port_pkg::CMD_RESTORE) begin
                if (to_a) o_wiper_a <= o_stored_a;
                if (to_b) o_wiper_b <= o_stored_b;
            end
        end
    end

    // Busy flag only informs; the link keeps accepting frames
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_count <= 32'h0;
        end else if (state == IDLE && sel_rise && valid && (cmd == wiper_port_pkg::CMD_WRITE_STORED
                     || cmd == wiper_port_pkg::CMD_SAVE)) begin
            busy_count <= 32'(wiper_port_pkg::STORE_BUSY_CYCLES);
        end else if (busy_count != 32'h0) begin
            busy_count <= busy_count - 32'h1;
        end
    end

    assign o_store_busy = (busy_count != 32'h0);
    assign o_ready = (state == IDLE);
endmodule : wiper_device

// ---- rtl/wiper_host.sv ----
// Host end: sends one command frame per request over the three-wire link
`timescale 1ns/1ns
module wiper_host (
    input wire logic i_clock,           // System clock
    input wire logic i_rst_b,           // Async reset
    input wire logic i_start,           // Send request, taken when o_ready
    input wire logic [1:0] i_command,   // Command field
    input wire logic [1:0] i_target,    // Target field
    input wire logic [7:0] i_code,      // Wiper code
    input wire logic i_short,           // Eight-clock frame for copy commands
    output logic o_ready,               // Idle and able to take a request
    output logic o_done,                // Pulse when a frame ends
    wiper_link_if.host link             // Serial link to device
);
    typedef enum logic [1:0] {IDLE = 2'b00, LOW = 2'b01, HIGH = 2'b11, GAP = 2'b10} state_t;

    state_t state;
    logic [15:0] frame;
    logic [4:0] left;
    logic [4:0] tick;
    logic step;

    assign step = (tick == 5'(wiper_port_pkg::LINK_HALF_CYCLES - 1));

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick <= 5'h00;
        end else if (state == IDLE || step) begin
            tick <= 5'h00;
        end else begin
            tick <= tick + 5'h01;
        end
    end

    // Select is held low for the whole frame and a gap follows
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= IDLE;
            frame <= 16'h0000;
            left <= 5'h00;
            link.select_b <= 1'b1;
            link.link_clock <= 1'b0;
            link.serial_data <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                IDLE: begin
                    if (i_start) begin
                        frame <= (i_short && i_command[1]) ? {2'b00, i_command, 2'b00, i_target, 8'h00}
                                                           : {2'b00, i_command, 2'b00, i_target, i_code};
                        left <= (i_short && i_command[1]) ? 5'(wiper_port_pkg::FRAME_SHORT)
                                                          : 5'(wiper_port_pkg::FRAME_LONG);
                        link.select_b <= 1'b0;
                        state <= LOW;
                    end
                end
                LOW: begin
                    if (step) begin
                        link.serial_data <= frame[15];
                        link.link_clock <= 1'b0;
                        state <= HIGH;
                    end
                end
                HIGH: begin
                    if (step) begin
                        link.link_clock <= 1'b1;
                        frame <= {frame[14:0], 1'b0};
                        left <= left - 5'h01;
                        state <= (left == 5'h01) ? GAP : LOW;
                    end
                end
                GAP: begin
                    if (step && link.select_b) begin
                        o_done <= 1'b1;
                        state <= IDLE;
                    end else if (step) begin
                        // Select stays high a full step so a back-to-back request cannot hide the rise
                        link.link_clock <= 1'b0;
                        link.select_b <= 1'b1;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    assign o_ready = (state == IDLE);
endmodule : wiper_host

// ---- bench/wiper_port_asserts.sv ----
// Link and register checks beside the host-device link
`timescale 1ns/1ns
module wiper_port_asserts (
    input wire logic i_clock, // Clock
    input wire logic i_rst_b, // Reset
    input wire logic select_b, // Select
    input wire logic link_clock, // Link clock
    input wire logic serial_data, // Data
    input wire logic [7:0] o_wiper_a, // Wiper A
    input wire logic [7:0] o_wiper_b, // Wiper B
    input wire logic [7:0] o_stored_a, // Stored A
    input wire logic [7:0] o_stored_b, // Stored B
    input wire logic o_ready // Ready
);
    localparam int SETTLE = 8;
    localparam int UP_LIMIT = 501;
    logic clk_q;
    logic sel_q;
    logic [4:0] rises;
    int since_rise;
    int up_count;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_q <= 1'b0;
            sel_q <= 1'b1;
        end else begin
            clk_q <= link_clock;
            sel_q <= select_b;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) rises <= 5'h00;
        else if (select_b) rises <= 5'h00;
        else if (link_clock && !clk_q) rises <= rises + 5'h01;
    end
    // Saturates so a long idle spell cannot wrap into a false match
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) since_rise <= 1000;
        else if (select_b && !sel_q) since_rise <= 0;
        else if (since_rise < 1000) since_rise <= since_rise + 1;
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) up_count <= 0;
        else if (up_count < 100000) up_count <= up_count + 1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence frame_open;
        $fell(select_b);
    endsequence
    sequence frame_close;
        $rose(select_b);
    endsequence
    chk_select_held: assert property (frame_open |-> !select_b [*8]) else $error("select short");
    chk_clock_idle: assert property (select_b |-> !link_clock) else $error("clock outside frame");
    chk_data_steady: assert property ($rose(link_clock) |-> $stable(serial_data)) else $error("data moved");
    chk_frame_count: assert property (frame_close |-> rises == 5'h10 || rises == 5'h08)
        else $error("bad clock count");
    chk_wiper_cause: assert property (o_ready && $past(o_ready) && ($changed(o_wiper_a) || $changed(o_wiper_b))
        |-> since_rise <= SETTLE) else $error("wiper moved unasked");
    chk_stored_cause: assert property (o_ready && $past(o_ready) && ($changed(o_stored_a) || $changed(o_stored_b))
        |-> since_rise <= SETTLE) else $error("store moved unasked");
    chk_powerup_load: assert property ($rose(o_ready) |-> o_wiper_a == o_stored_a && o_wiper_b == o_stored_b)
        else $error("wipers not loaded");
    chk_powerup_time: assert property ($rose(o_ready) |-> up_count <= UP_LIMIT) else $error("power-up slow");
    chk_midscale_start: assert property ($rose(i_rst_b) |-> o_stored_a == 8'h80 && o_stored_b == 8'h80)
        else $error("store not midscale");
endmodule : wiper_port_asserts

// ---- bench/test_dual_wiper_serial_command_port.sv ----
// Bench joining host and device ends over the three-wire link
`timescale 1ns/1ns
module test_dual_wiper_serial_command_port;
    logic i_clock;
    logic i_rst_b = 1'b0;
    logic i_start = 1'b0;
    logic [1:0] i_command = 2'h0;
    logic [1:0] i_target = 2'h0;
    logic [7:0] i_code = 8'h00;
    logic i_short = 1'b0;
    logic h_ready;
    logic h_done;
    logic [7:0] wa;
    logic [7:0] wb;
    logic [7:0] sa;
    logic [7:0] sb;
    logic d_ready;
    logic d_busy;
    logic [15:0] wire_bits = 16'h0000;
    int wire_count = 0;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    wiper_link_if link ();
    wiper_host wiper_host_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(i_start), .i_command(i_command),
        .i_target(i_target), .i_code(i_code), .i_short(i_short), .o_ready(h_ready), .o_done(h_done), .link(link.host));
    wiper_device wiper_device_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .link(link.device), .o_wiper_a(wa),
        .o_wiper_b(wb), .o_stored_a(sa), .o_stored_b(sb), .o_ready(d_ready), .o_store_busy(d_busy));
    wiper_port_asserts wiper_port_asserts_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .select_b(link.select_b),
        .link_clock(link.link_clock), .serial_data(link.serial_data), .o_wiper_a(wa), .o_wiper_b(wb),
        .o_stored_a(sa), .o_stored_b(sb), .o_ready(d_ready));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge link.link_clock) begin
        wire_bits = {wire_bits[14:0], link.serial_data};
        wire_count = wire_count + 1;
    end
    always @(negedge link.select_b) wire_count = 0;
    always @(posedge i_clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic expect_all(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] esa, input logic [7:0] esb);
        check8(wa, ea);
        check8(wb, eb);
        check8(sa, esa);
        check8(sb, esb);
    endtask : expect_all
    // Power-up is modelled by reset, so the store returns to midscale too
    task automatic test_powerup();
        i_rst_b = 1'b0;
        repeat (6) @(negedge i_clock);
        i_rst_b = 1'b1;
        for (int n = 0; n < 1000 && d_ready !== 1'b1; n++) @(negedge i_clock);
        check8(8'(d_ready), 8'h01);
        check8(8'(d_busy), 8'h00);
        expect_all(8'h80, 8'h80, 8'h80, 8'h80);
        $display("powerup done");
    endtask : test_powerup
    task automatic send(input logic [1:0] cmd, input logic [1:0] tgt, input logic [7:0] code, input logic sh);
        @(negedge i_clock);
        {i_command, i_target, i_code, i_short} = {cmd, tgt, code, sh};
        i_start = 1'b1;
        @(negedge i_clock);
        i_start = 1'b0;
        for (int n = 0; n < 2000 && h_done !== 1'b1; n++) @(negedge i_clock);
        check8(8'(h_done), 8'h01);
        repeat (10) @(negedge i_clock);
        check8(8'(h_ready), 8'h01);
        check8(sh ? wire_bits[7:0] : wire_bits[15:8], {2'h0, cmd, 2'h0, tgt});
        if (!sh) check8(wire_bits[7:0], code);
        check8(8'(wire_count), sh ? 8'h08 : 8'h10);
    endtask : send
    task automatic test_writes();
        send(wiper_port_pkg::CMD_WRITE_WIPER, wiper_port_pkg::TARGET_A, 8'h00, 1'b0);
        send(wiper_port_pkg::CMD_WRITE_WIPER, wiper_port_pkg::TARGET_B, 8'hFF, 1'b0);
        expect_all(8'h00, 8'hFF, 8'h80, 8'h80);
        check8(8'(d_busy), 8'h00);
        send(wiper_port_pkg::CMD_WRITE_STORED, wiper_port_pkg::TARGET_A, 8'h3C, 1'b0);
        expect_all(8'h00, 8'hFF, 8'h3C, 8'h80);
        check8(8'(d_busy), 8'h01);
        $display("writes done");
    endtask : test_writes
    task automatic test_copies();
        send(wiper_port_pkg::CMD_SAVE, wiper_port_pkg::TARGET_BOTH, 8'h00, 1'b1);
        expect_all(8'h00, 8'hFF, 8'h00, 8'hFF);
        send(wiper_port_pkg::CMD_WRITE_STORED, wiper_port_pkg::TARGET_B, 8'hA5, 1'b0);
        send(wiper_port_pkg::CMD_RESTORE, wiper_port_pkg::TARGET_B, 8'h11, 1'b0);
        expect_all(8'h00, 8'hA5, 8'h00, 8'hA5);
        $display("copies done");
    endtask : test_copies
    task automatic test_refused();
        send(wiper_port_pkg::CMD_WRITE_WIPER, wiper_port_pkg::TARGET_BOTH, 8'h77, 1'b0);
        send(wiper_port_pkg::CMD_WRITE_STORED, wiper_port_pkg::TARGET_NONE, 8'h66, 1'b0);
        send(wiper_port_pkg::CMD_RESTORE, wiper_port_pkg::TARGET_NONE, 8'h00, 1'b1);
        expect_all(8'h00, 8'hA5, 8'h00, 8'hA5);
        $display("refused done");
    endtask : test_refused
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        test_powerup();
        test_writes();
        test_copies();
        test_refused();
        test_powerup();
        report_and_stop();
    end
endmodule : test_dual_wiper_serial_command_port
